//--- design/ep_cfg_defs.svh
// Register offsets, field positions, codes and configuration register reset value of the endpoint configuration block
`ifndef EP_CFG_DEFS_SVH
`define EP_CFG_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFS_EPCFG      12'h000
`define OFS_CMD        12'h004
`define OFS_INT_STS    12'h008
`define OFS_INT_MASK   12'h00C

// ==========================================================
// Endpoint configuration register fields
`define BIT_PKT_DUAL   15
`define BIT_DIRECT     14
`define TOG_HI         13
`define TOG_LO         12
`define COND_HI        11
`define COND_LO        9
`define BIT_BLOCK      8
`define BIT_DIR        7
`define TT_HI          3
`define TT_LO          2
`define TPF_HI         1
`define TPF_LO         0
`define EPCFG_RESET    32'h0000_0000

// ==========================================================
// Endpoint condition codes
`define COND_READY     3'h0
`define COND_ERROR     3'h2
`define COND_STALL     3'h3
`define COND_INVALID   3'h7

// ==========================================================
// Command codes written to the command register
`define CMD_CLEAR      8'h01
`define CMD_HALT       8'h02
`define CMD_BLOCK      8'h03
`define CMD_ALLOW      8'h04
`define CMD_INVALID    8'h05

// ==========================================================
// Interrupt bits
`define INT_W          3
`define INT_ERROR      0
`define INT_STALL      1
`define INT_NAK        2

`endif

//--- design/ep_cfg_pkg.sv
// Types shared by the endpoint configuration block
`include "ep_cfg_defs.svh"

package ep_cfg_pkg;

  // ========================================================
  // Complete state of the block
  typedef struct packed {
    logic                pkt_dual;
    logic                direct;
    logic [1:0]          toggle;
    logic [2:0]          cond;
    logic                block;
    logic                dir_in;
    logic [1:0]          xfer_type;
    logic [1:0]          tpf;
    logic [`INT_W-1:0]   int_sts;
    logic [`INT_W-1:0]   int_mask;
    logic                irq;
    logic                nak;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } state_s;

endpackage : ep_cfg_pkg

//--- design/ep_cfg.sv
// Endpoint status and configuration register with APB access, commands and interrupt
`timescale 1ns/1ps
`include "ep_cfg_defs.svh"

// Contract
// - bit 15 selects single or dual buffering
// - bit 14 selects shared bus or direct path
// - bits 13-12 report present data toggle
// - bits 11-9 encode ready/error/stall/invalid
// - clear command returns condition to ready
// - receive error or timeout sets error
// - error never overwrites stall or invalid
// - halt command sets stall condition
// - bit 8 blocks; blocked tokens get NAK
// - bit 7 selects OUT or IN direction
// - bits 3-2 select transfer category
// - bits 1-0 give isochronous transactions per frame
module ep_cfg (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Events from the packet engine
  input  wire logic        rx_data_err_i,
  input  wire logic        tx_timeout_i,
  input  wire logic        toggle_load_i,
  input  wire logic [1:0]  toggle_value_i,
  input  wire logic        token_i,
  // Configuration to the packet engine
  output logic             pkt_dual_o,
  output logic             direct_path_o,
  output logic             dir_in_o,
  output logic      [1:0]  xfer_type_o,
  output logic      [1:0]  tpf_o,
  output logic      [2:0]  cond_o,
  output logic             blocked_o,
  output logic             nak_o,
  // Interrupt
  output logic             irq_o
);

  ep_cfg_pkg::state_s s_q;
  ep_cfg_pkg::state_s s_d;

  // ========================================================
  // Register image read back by software
  function automatic logic [31:0] epcfg_word(input ep_cfg_pkg::state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`BIT_PKT_DUAL]     = s.pkt_dual;
    w[`BIT_DIRECT]       = s.direct;
    w[`TOG_HI:`TOG_LO]   = s.toggle;
    w[`COND_HI:`COND_LO] = s.cond;
    w[`BIT_BLOCK]        = s.block;
    w[`BIT_DIR]          = s.dir_in;
    w[`TT_HI:`TT_LO]     = s.xfer_type;
    w[`TPF_HI:`TPF_LO]   = s.tpf;
    return w;
  endfunction : epcfg_word

  // Address decode shared by read and write paths
  function automatic logic addr_hit(input logic [11:0] a);
    return (a == `OFS_EPCFG) || (a == `OFS_CMD) || (a == `OFS_INT_STS) || (a == `OFS_INT_MASK);
  endfunction : addr_hit

  logic       wr_done;
  logic [7:0] cmd;
  logic       hw_err;
  logic [`INT_W-1:0] ev;

  always_comb begin
    s_d     = s_q;
    wr_done = psel_i && penable_i && s_q.pready && pwrite_i && addr_hit(paddr_i);
    cmd     = (wr_done && paddr_i == `OFS_CMD) ? pwdata_i[7:0] : 8'h00;
    hw_err  = rx_data_err_i || tx_timeout_i;
    ev      = '0;

    // APB: setup cycle prepares the answer, access cycle completes
    s_d.pready  = psel_i && !penable_i;
    s_d.pslverr = psel_i && !penable_i && !addr_hit(paddr_i);
    s_d.prdata  = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `OFS_EPCFG:    s_d.prdata = epcfg_word(s_q);
        `OFS_INT_STS:  s_d.prdata = {29'h0000_0000, s_q.int_sts};
        `OFS_INT_MASK: s_d.prdata = {29'h0000_0000, s_q.int_mask};
        default:       s_d.prdata = 32'h0000_0000;
      endcase
    end

    // Software fields; read-only and unused bits are dropped
    if (wr_done && paddr_i == `OFS_EPCFG) begin
      s_d.pkt_dual  = pwdata_i[`BIT_PKT_DUAL];
      s_d.direct    = pwdata_i[`BIT_DIRECT];
      s_d.dir_in    = pwdata_i[`BIT_DIR];
      s_d.xfer_type = pwdata_i[`TT_HI:`TT_LO];
      s_d.tpf       = pwdata_i[`TPF_HI:`TPF_LO];
    end
    if (wr_done && paddr_i == `OFS_INT_MASK) begin
      s_d.int_mask = pwdata_i[`INT_W-1:0];
    end

    // Present toggle follows the packet engine
    if (toggle_load_i) begin
      s_d.toggle = toggle_value_i;
    end

    // Condition: hardware error first, software commands override
    if (hw_err && s_q.cond != `COND_STALL && s_q.cond != `COND_INVALID) begin
      s_d.cond = `COND_ERROR;
    end
    case (cmd)
      `CMD_CLEAR: begin
        s_d.cond   = `COND_READY;
        s_d.toggle = 2'h0;
      end
      `CMD_HALT: begin
        s_d.cond = `COND_STALL;
        ev[`INT_STALL] = 1'b1;
      end
      `CMD_BLOCK:   s_d.block = 1'b1;
      `CMD_ALLOW:   s_d.block = 1'b0;
      `CMD_INVALID: s_d.cond  = `COND_INVALID;
      default:      s_d.block = s_d.block;
    endcase
    // Error interrupt only on entry into error, not when a command wins
    ev[`INT_ERROR] = (s_d.cond == `COND_ERROR) && (s_q.cond != `COND_ERROR);

    // Blocked endpoint answers every token with NAK
    s_d.nak = token_i && s_q.block;
    ev[`INT_NAK] = s_d.nak;

    // Sticky status, write one to clear, a new event wins
    s_d.int_sts = s_q.int_sts;
    if (wr_done && paddr_i == `OFS_INT_STS) begin
      s_d.int_sts = s_q.int_sts & ~pwdata_i[`INT_W-1:0];
    end
    s_d.int_sts = s_d.int_sts | ev;
    s_d.irq     = |(s_d.int_sts & s_d.int_mask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================
  // Outputs
  assign prdata_o      = s_q.prdata;
  assign pready_o      = s_q.pready;
  assign pslverr_o     = s_q.pslverr;
  assign pkt_dual_o    = s_q.pkt_dual;
  assign direct_path_o = s_q.direct;
  assign dir_in_o      = s_q.dir_in;
  assign xfer_type_o   = s_q.xfer_type;
  assign tpf_o         = s_q.tpf;
  assign cond_o        = s_q.cond;
  assign blocked_o     = s_q.block;
  assign nak_o         = s_q.nak;
  assign irq_o         = s_q.irq;

  // ========================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_cfg_write;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == `OFS_EPCFG;
  endsequence

  sequence s_cmd(logic [7:0] c);
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == `OFS_CMD && pwdata_i[7:0] == c;
  endsequence

  property p_dual_mode;
    s_cfg_write |=> pkt_dual_o == $past(pwdata_i[`BIT_PKT_DUAL]);
  endproperty
  a_dual_mode: assert property (p_dual_mode) else $error("dual mode bit not stored");

  property p_path_sel;
    s_cfg_write |=> direct_path_o == $past(pwdata_i[`BIT_DIRECT]) && dir_in_o == $past(pwdata_i[`BIT_DIR]);
  endproperty
  a_path_sel: assert property (p_path_sel) else $error("path or direction not stored");

  property p_toggle;
    toggle_load_i && !(psel_i && penable_i && pready_o && pwrite_i && paddr_i == `OFS_CMD)
      |=> s_q.toggle == $past(toggle_value_i);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not loaded");

  property p_cond_legal;
    cond_o == `COND_READY || cond_o == `COND_ERROR || cond_o == `COND_STALL || cond_o == `COND_INVALID;
  endproperty
  a_cond_legal: assert property (p_cond_legal) else $error("reserved condition code");

  property p_clear;
    s_cmd(`CMD_CLEAR) |=> cond_o == `COND_READY;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not give ready");

  property p_error;
    (rx_data_err_i || tx_timeout_i) && cond_o == `COND_READY && !(psel_i && penable_i && pwrite_i)
      |=> cond_o == `COND_ERROR && s_q.int_sts[`INT_ERROR] && (irq_o || !s_q.int_mask[`INT_ERROR]);
  endproperty
  a_error: assert property (p_error) else $error("error not flagged");

  property p_no_err_over_stall;
    (cond_o == `COND_STALL || cond_o == `COND_INVALID) && !(psel_i && penable_i && pwrite_i)
      |=> cond_o == $past(cond_o);
  endproperty
  a_no_err_over_stall: assert property (p_no_err_over_stall) else $error("stall or invalid overwritten");

  property p_halt;
    s_cmd(`CMD_HALT) |=> cond_o == `COND_STALL && s_q.int_sts[`INT_STALL];
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stall");

  property p_nak;
    token_i |=> nak_o == $past(blocked_o);
  endproperty
  a_nak: assert property (p_nak) else $error("nak does not follow block");

  property p_type;
    s_cfg_write |=> xfer_type_o == $past(pwdata_i[`TT_HI:`TT_LO]) && tpf_o == $past(pwdata_i[`TPF_HI:`TPF_LO]);
  endproperty
  a_type: assert property (p_type) else $error("type or transactions field not stored");

  property p_ro_fields;
    s_cfg_write and (!toggle_load_i && !rx_data_err_i && !tx_timeout_i && !token_i)
      |=> $stable(cond_o) && $stable(blocked_o) && $stable(s_q.toggle);
  endproperty
  a_ro_fields: assert property (p_ro_fields) else $error("read-only field changed by write");

  property p_apb_answer;
    psel_i && !penable_i |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

  sequence s_cfg_read;
    psel_i && !penable_i && !pwrite_i && paddr_i == `OFS_EPCFG;
  endsequence

  property p_block_cmd;
    s_cmd(`CMD_BLOCK) |=> blocked_o;
  endproperty
  a_block_cmd: assert property (p_block_cmd) else $error("block command not taken");

  property p_allow_cmd;
    s_cmd(`CMD_ALLOW) |=> !blocked_o;
  endproperty
  a_allow_cmd: assert property (p_allow_cmd) else $error("allow command not taken");

  property p_invalid_cmd;
    s_cmd(`CMD_INVALID) |=> cond_o == `COND_INVALID;
  endproperty
  a_invalid_cmd: assert property (p_invalid_cmd) else $error("invalid command not taken");

  property p_clear_toggle;
    s_cmd(`CMD_CLEAR) |=> s_q.toggle == 2'h0 && blocked_o == $past(blocked_o);
  endproperty
  a_clear_toggle: assert property (p_clear_toggle) else $error("clear did not reset toggle only");

  property p_nak_sts;
    token_i && blocked_o |=> nak_o && s_q.int_sts[`INT_NAK];
  endproperty
  a_nak_sts: assert property (p_nak_sts) else $error("blocked token not answered with nak");

  property p_no_token;
    !token_i |=> !nak_o;
  endproperty
  a_no_token: assert property (p_no_token) else $error("nak without token");

  property p_stall_sticky;
    s_q.int_sts[`INT_STALL] && !(psel_i && penable_i && pwrite_i) |=> s_q.int_sts[`INT_STALL];
  endproperty
  a_stall_sticky: assert property (p_stall_sticky) else $error("halt status bit lost");

  property p_cfg_hold;
    !(psel_i && penable_i && pwrite_i)
      |=> $stable(pkt_dual_o) && $stable(direct_path_o) && $stable(dir_in_o)
          && $stable(xfer_type_o) && $stable(tpf_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed without write");

  property p_unmapped;
    psel_i && !penable_i && !addr_hit(paddr_i) |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_mapped;
    psel_i && !penable_i && addr_hit(paddr_i) |=> pready_o && !pslverr_o;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");

  property p_read_fields;
    s_cfg_read |=> prdata_o[`COND_HI:`COND_LO] == $past(cond_o) && prdata_o[`BIT_BLOCK] == $past(blocked_o);
  endproperty
  a_read_fields: assert property (p_read_fields) else $error("condition or block bit misread");

  property p_read_toggle;
    s_cfg_read |=> prdata_o[`TOG_HI:`TOG_LO] == $past(s_q.toggle) && prdata_o[`BIT_DIR] == $past(dir_in_o);
  endproperty
  a_read_toggle: assert property (p_read_toggle) else $error("toggle or direction misread");

  property p_read_mode;
    s_cfg_read |=> prdata_o[`BIT_PKT_DUAL] == $past(pkt_dual_o) && prdata_o[`BIT_DIRECT] == $past(direct_path_o);
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("buffering or path bit misread");

  property p_read_unused;
    s_cfg_read |=> prdata_o[31:16] == 16'h0000 && prdata_o[6:4] == 3'h0;
  endproperty
  a_read_unused: assert property (p_read_unused) else $error("unused bits not zero");

endmodule : ep_cfg

//--- verification/usb_host_model.sv
// Far-side model that emits packet engine events on request
`timescale 1ns/1ps
module usb_host_model (
  // Clock, reset and request from the bench
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  input  wire logic [1:0] val_i,
  // Event pulses to the block
  output logic            rx_data_err_o,
  output logic            tx_timeout_o,
  output logic            token_o,
  output logic            toggle_load_o,
  output logic      [1:0] toggle_value_o
);
  // ==========================================================
  // One-cycle event pulses
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      {rx_data_err_o, tx_timeout_o, token_o, toggle_load_o, toggle_value_o} <= 6'h00;
    end else begin
      rx_data_err_o <= go_i && kind_i == 2'h0;
      tx_timeout_o  <= go_i && kind_i == 2'h1;
      token_o       <= go_i && kind_i == 2'h2;
      toggle_load_o <= go_i && kind_i == 2'h3;
      // Toggle value is junk outside a load
      toggle_value_o <= go_i ? val_i : ~toggle_value_o;
    end
  end
endmodule : usb_host_model

//--- verification/tb.sv
// Self-checking bench for the endpoint configuration block
`timescale 1ns/1ps
`include "ep_cfg_defs.svh"
module tb;
  // ==========================================================
  // Signals
  logic clk_sys_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, go = 0, e, n_seen;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, pwd, e_cfg = 32'h0000_0000, prdata_o;
  logic [1:0] kind = 2'h0, val = 2'h0, tv, xfer_type_o, tpf_o, e_tog = 2'h0;
  logic [2:0] cond_o, e_cond = 3'h0;
  logic pready_o, pslverr_o, rxe, txt, tok, tl, pkt_dual_o, direct_path_o, dir_in_o;
  logic blocked_o, nak_o, irq_o, e_blk = 0;
  int errors = 0, cmp_count = 0, seed = 32'hc76c;

  always #5 clk_sys_i = ~clk_sys_i;

  ep_cfg ep_cfg_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_data_err_i(rxe), .tx_timeout_i(txt), .toggle_load_i(tl),
    .toggle_value_i(tv), .token_i(tok), .pkt_dual_o(pkt_dual_o), .direct_path_o(direct_path_o),
    .dir_in_o(dir_in_o), .xfer_type_o(xfer_type_o), .tpf_o(tpf_o), .cond_o(cond_o),
    .blocked_o(blocked_o), .nak_o(nak_o), .irq_o(irq_o));
  usb_host_model usb_host_model_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .go_i(go),
    .kind_i(kind), .val_i(val), .rx_data_err_o(rxe), .tx_timeout_o(txt), .token_o(tok),
    .toggle_load_o(tl), .toggle_value_o(tv));

  // ==========================================================
  // Helpers
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk

  function logic [31:0] exp_cfg();
    return {16'h0000, e_cfg[15:14], e_tog, e_cond, e_blk, e_cfg[7], 3'h0, e_cfg[3:0]};
  endfunction : exp_cfg

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    e = pslverr_o;
    chk(pready_o, 1, "ready");
    psel <= 0; penable <= 0;
    @(posedge clk_sys_i);
  endtask : apb

  task ev(input logic [1:0] k, input logic [1:0] v);
    go <= 1; kind <= k; val <= v;
    @(posedge clk_sys_i);
    go <= 0;
    @(posedge clk_sys_i);
    #1 n_seen = nak_o;
    repeat (2) @(posedge clk_sys_i);
  endtask : ev

  task settle();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : settle

  task rd_cfg();
    apb(0, `OFS_EPCFG, 0);
    chk(rd, exp_cfg(), "cfg");
    chk({pkt_dual_o, direct_path_o, dir_in_o, xfer_type_o, tpf_o, cond_o, blocked_o},
        {e_cfg[15:14], e_cfg[7], e_cfg[3:0], e_cond, e_blk}, "pins");
  endtask : rd_cfg

  task cmd(input logic [7:0] c);
    apb(1, `OFS_CMD, {24'h00_0000, c});
  endtask : cmd

  task end_sim();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 0;
    @(posedge clk_sys_i);
    rd_cfg();
    for (int i = 0; i < 8; i++) begin
      pwd = $random(seed);
      if (i < 4) pwd[3:0] = {i[1:0], i[1:0]};
      if (i == 7) pwd[`BIT_DIRECT] = 1'b1;
      apb(1, `OFS_EPCFG, pwd);
      e_cfg = pwd & 32'h0000_C08F;
      rd_cfg();
    end
    for (int i = 0; i < 4; i++) begin
      ev(3, i[1:0]);
      e_tog = i[1:0];
      rd_cfg();
    end
    cmd(`CMD_HALT); e_cond = `COND_STALL;
    ev(0, 0); rd_cfg();
    cmd(`CMD_INVALID); e_cond = `COND_INVALID;
    ev(1, 0); rd_cfg();
    cmd(`CMD_CLEAR); e_cond = `COND_READY; e_tog = 2'h0;
    rd_cfg();
    ev(0, 0); e_cond = `COND_ERROR;
    rd_cfg();
    cmd(`CMD_CLEAR); e_cond = `COND_READY;
    ev(1, 0); e_cond = `COND_ERROR;
    rd_cfg();
    apb(0, `OFS_INT_STS, 0); chk(rd, 32'h0000_0003, "sts"); chk(irq_o, 0, "irq");
    apb(1, `OFS_INT_STS, 32'h0000_0007); apb(0, `OFS_INT_STS, 0); chk(rd, 0, "w1c");
    apb(1, `OFS_INT_MASK, 32'h0000_0004); apb(0, `OFS_INT_MASK, 0); chk(rd, 4, "mask");
    cmd(`CMD_BLOCK); e_blk = 1;
    ev(2, 0); chk(n_seen, 1, "nak");
    settle(); chk(irq_o, 1, "irq on");
    apb(1, `OFS_INT_MASK, 0); settle(); chk(irq_o, 0, "irq masked");
    apb(1, `OFS_INT_MASK, 32'h0000_0004); settle(); chk(irq_o, 1, "irq unmasked");
    apb(1, `OFS_INT_STS, 32'h0000_0004); settle(); chk(irq_o, 0, "irq cleared");
    rd_cfg();
    cmd(`CMD_ALLOW); e_blk = 0;
    ev(2, 0); chk(n_seen, 0, "no nak");
    apb(0, `OFS_INT_STS, 0); chk(rd, 0, "no nak sts");
    apb(1, 12'h010, 32'hFFFF_FFFF); chk(e, 1, "slverr w");
    apb(0, 12'h010, 0);
    chk(e, 1, "slverr r");
    chk(rd, 32'h0000_0000, "slverr rd");
    rd_cfg();
    // Reset in mid-run returns every field to its reset value
    reset_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 0;
    @(posedge clk_sys_i);
    e_cfg = 32'h0000_0000;
    e_cond = `COND_READY;
    e_tog = 2'h0;
    e_blk = 0;
    rd_cfg();
    apb(0, `OFS_INT_STS, 0);
    chk(rd, 32'h0000_0000, "sts after reset");
    end_sim();
  end

  initial begin
    #50us;
    errors++;
    end_sim();
  end
endmodule : tb
